// >>> rtl/lpps_top.sv
// lcd panel power sequencer: supply pins, display enable, output gating,
// power state and vsync interrupt flag, apb register slave.
// assumes frameTick and retrace pulses come from the timing generator on ref_clk.
`timescale 1ns/100ps
module lpps_top
   import lpps_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // timing generator events, same clock
   input  wire logic        frameTick,
   input  wire logic        memRetraceStart,
   input  wire logic        dispRetraceStart,
   // panel side
   output lpps_pins_s       panelPins,
   output logic             controllerRun,
   output logic             panelCtrlIrq
);
   logic [15:0]  pmode_r;
   logic [15:0]  pstep_r;
   logic         don_r;
   logic         startAux_r;
   logic         vsel_r;
   logic         ven_r;
   logic         vflag_r;
   lpps_state_e  state_r;
   lpps_state_e  state_nxt;
   logic [3:0]   cnt_r;
   lpps_pins_s   pins_r;
   logic         run_r;

   // state groups, shared by the pin decode, the power state and the checks
   function automatic logic isLive(input lpps_state_e s);
      return s != SQ_OFF;
   endfunction

   // display data and timing run from the end of the first on-step
   // to the end of the second off-step
   function automatic logic isOutputting(input lpps_state_e s);
      return (s != SQ_OFF) && (s != SQ_SUP_OUT) && (s != SQ_OUT_SUP);
   endfunction

   // bias supply stands from the third on-step to the end of the first off-step
   function automatic logic isBiased(input lpps_state_e s);
      return (s == SQ_BIAS_EN) || (s == SQ_ON) || (s == SQ_EN_BIAS);
   endfunction

   // power state stays on through the off-sequence, so software that polls
   // for off waits until the last supply has dropped
   function automatic logic isReportedOn(input lpps_state_e s);
      return (s == SQ_ON) || (s == SQ_EN_BIAS) || (s == SQ_BIAS_OUT) || (s == SQ_OUT_SUP);
   endfunction

   // timed steps are every state but the two resting ones
   function automatic logic isStep(input lpps_state_e s);
      return (s != SQ_OFF) && (s != SQ_ON);
   endfunction

   // bus decode; zero-wait-state slave, so pready never stalls the master
   wire wrEn   = psel & penable & pwrite;
   wire hitMd  = paddr == ADDR_PMODE;
   wire hitSt  = paddr == ADDR_PSTEP;
   wire hitDc  = paddr == ADDR_DCTRL;
   wire hitIq  = paddr == ADDR_IRQCTL;
   wire mapped = hitMd | hitSt | hitDc | hitIq;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // reserved and read-only bits of the mode word are never stored
   wire [15:0] pmodeWr = pwdata[15:0] & PMODE_WMASK;

   // step fields
   wire [3:0] supOutLen  = pstep_r[SUP_OUT_STEP_LSB +: STEP_W];
   wire [3:0] outBiasLen = pstep_r[OUT_BIAS_STEP_LSB +: STEP_W];
   wire [3:0] biasEnLen  = pmode_r[BIAS_EN_STEP_LSB +: STEP_W];
   wire [3:0] enBiasLen  = pmode_r[EN_BIAS_STEP_LSB +: STEP_W];
   wire [3:0] biasOutLen = pstep_r[BIAS_OUT_STEP_LSB +: STEP_W];
   wire [3:0] outSupLen  = pstep_r[OUT_SUP_STEP_LSB +: STEP_W];
   wire [1:0] pwrState   = isReportedOn(state_r) ? PWR_STATE_ON : PWR_STATE_OFF;

   // step ends after the programmed count plus one frames
   wire [3:0] stepLen = (state_r == SQ_SUP_OUT)  ? supOutLen  :
                        (state_r == SQ_OUT_BIAS) ? outBiasLen :
                        (state_r == SQ_BIAS_EN)  ? biasEnLen  :
                        (state_r == SQ_EN_BIAS)  ? enBiasLen  :
                        (state_r == SQ_BIAS_OUT) ? biasOutLen : outSupLen;
   wire stepDone = frameTick & (cnt_r == stepLen);

   // vsync event at the selected retrace start
   wire vsEvent = ven_r & (vsel_r ? dispRetraceStart : memRetraceStart);
   wire vClear  = wrEn & hitIq & ~pwdata[IRQ_FLAG_BIT];

   // next state of the power sequence
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         SQ_OFF:      if (don_r) state_nxt = SQ_SUP_OUT;
         SQ_SUP_OUT:  if (stepDone) state_nxt = SQ_OUT_BIAS;
         SQ_OUT_BIAS: if (stepDone) state_nxt = SQ_BIAS_EN;
         SQ_BIAS_EN:  if (stepDone) state_nxt = SQ_ON;
         SQ_ON:       if (!don_r) state_nxt = SQ_EN_BIAS;
         SQ_EN_BIAS:  if (stepDone) state_nxt = SQ_BIAS_OUT;
         SQ_BIAS_OUT: if (stepDone) state_nxt = SQ_OUT_SUP;
         SQ_OUT_SUP:  if (stepDone) state_nxt = SQ_OFF;
      endcase
   end

   // pin levels per state, supplies and display enable masked by the per-pin enables; resolution, depth
   // and rotation belong to the fetch engine, this block only gates its outputs
   lpps_pins_s pinsNxt;
   always_comb begin
      pinsNxt.logicSupply = pmode_r[LOGIC_PIN_EN_BIT] & isLive(state_nxt);
      pinsNxt.outputsOn   = isOutputting(state_nxt);
      pinsNxt.biasSupply  = pmode_r[BIAS_PIN_EN_BIT] & isBiased(state_nxt);
      pinsNxt.dispEnable  = pmode_r[DISP_PIN_EN_BIT] & (state_nxt == SQ_ON);
   end

   // sequencer registers; pins follow the next state so they move with it
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= SQ_OFF;
         cnt_r   <= 4'h0;
         pins_r  <= '0;
         run_r   <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (state_nxt != state_r) cnt_r <= 4'h0;
         else if (frameTick) cnt_r <= cnt_r + 4'h1;
         pins_r  <= pinsNxt;
         run_r   <= isLive(state_nxt);
      end
   end

   // software registers
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pmode_r    <= PMODE_RST;
         pstep_r    <= PSTEP_RST;
         don_r      <= 1'b0;
         startAux_r <= 1'b0;
         vsel_r     <= 1'b0;
         ven_r      <= 1'b0;
      end else begin
         if (wrEn && hitMd) pmode_r <= pmodeWr;
         if (wrEn && hitSt) pstep_r <= pwdata[15:0];
         if (wrEn && hitDc) begin
            don_r      <= pwdata[DISP_ON_BIT];
            startAux_r <= pwdata[START_AUX_BIT];
         end else begin
            startAux_r <= 1'b0;
         end
         if (wrEn && hitIq) begin
            vsel_r <= pwdata[IRQ_POINT_BIT];
            ven_r  <= pwdata[IRQ_EN_BIT];
         end
      end
   end

   // vsync flag: event wins over a clearing write, so no retrace is ever lost
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) vflag_r <= 1'b0;
      else if (vsEvent) vflag_r <= 1'b1;
      else if (vClear) vflag_r <= 1'b0;
   end

   // read mux; reserved bits read zero
   logic [15:0] rdWord;
   always_comb begin
      rdWord = 16'h0000;
      if (hitMd) rdWord = {pmode_r[15:2], pwrState};
      if (hitSt) rdWord = pstep_r;
      if (hitDc) begin
         rdWord[START_AUX_BIT] = startAux_r;
         rdWord[DISP_ON_BIT]   = don_r;
      end
      if (hitIq) begin
         rdWord[IRQ_POINT_BIT] = vsel_r;
         rdWord[IRQ_EN_BIT]    = ven_r;
         rdWord[IRQ_FLAG_BIT]  = vflag_r;
      end
   end
   assign prdata        = {16'h0000, rdWord & {16{psel}}};
   assign panelPins     = pins_r;
   assign controllerRun = run_r;
   assign panelCtrlIrq  = vflag_r;

   // assertions: interrupt flag
   chk_flag_set: assert property (@(posedge ref_clk) disable iff (!resetn)
      vsEvent |=> vflag_r) else $error("vsync flag not set");
   chk_flag_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
      (vClear && !vsEvent) |=> !vflag_r) else $error("vsync flag not cleared");
   chk_irq_enable: assert property (@(posedge ref_clk) disable iff (!resetn)
      (!vflag_r && !ven_r) |=> !vflag_r) else $error("flag set while disabled");
   chk_vsel_point: assert property (@(posedge ref_clk) disable iff (!resetn)
      (ven_r && vsel_r && memRetraceStart && !dispRetraceStart && !vflag_r)
      |=> !vflag_r) else $error("wrong retrace point");

   // assertions: pin masks
   chk_logic_mask: assert property (@(posedge ref_clk) disable iff (!resetn)
      !pmode_r[LOGIC_PIN_EN_BIT] |=> !panelPins.logicSupply)
      else $error("logic pin not masked");
   chk_bias_mask: assert property (@(posedge ref_clk) disable iff (!resetn)
      !pmode_r[BIAS_PIN_EN_BIT] |=> !panelPins.biasSupply)
      else $error("bias pin not masked");
   chk_enable_mask: assert property (@(posedge ref_clk) disable iff (!resetn)
      !pmode_r[DISP_PIN_EN_BIT] |=> !panelPins.dispEnable)
      else $error("enable pin not masked");

   // assertions: reported power state at the two sequence ends
   chk_state_on: assert property (@(posedge ref_clk) disable iff (!resetn)
      (state_r == SQ_BIAS_EN && stepDone) |=> pwrState == PWR_STATE_ON)
      else $error("power state not on");
   chk_state_off: assert property (@(posedge ref_clk) disable iff (!resetn)
      (state_r == SQ_OUT_SUP && stepDone) |=> pwrState == PWR_STATE_OFF)
      else $error("power state not off");

   // assertions: start auxiliary bit
   sequence seqAuxWrite;
      wrEn && hitDc && pwdata[START_AUX_BIT];
   endsequence
   chk_aux_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
      (startAux_r && !(wrEn && hitDc)) |=> !startAux_r) else $error("aux bit stuck");
   chk_aux_pulse: assert property (@(posedge ref_clk) disable iff (!resetn)
      seqAuxWrite |=> startAux_r ##1 !startAux_r) else $error("aux bit not one pulse");

   // assertions: start and stop requests
   sequence seqStartReq;
      state_r == SQ_OFF && don_r;
   endsequence
   sequence seqStopReq;
      state_r == SQ_ON && !don_r;
   endsequence
   chk_on_start: assert property (@(posedge ref_clk) disable iff (!resetn)
      seqStartReq |=> state_r == SQ_SUP_OUT ##1 controllerRun) else $error("start failed");
   chk_off_start: assert property (@(posedge ref_clk) disable iff (!resetn)
      seqStopReq |=> state_r == SQ_EN_BIAS) else $error("stop failed");
   chk_enable_drop: assert property (@(posedge ref_clk) disable iff (!resetn)
      seqStopReq |=> !panelPins.dispEnable) else $error("enable pin held after stop");

   // assertions: step timing
   chk_step_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
      (state_r == SQ_BIAS_EN && !frameTick) |=> state_r == SQ_BIAS_EN)
      else $error("step left early");
   chk_step_early: assert property (@(posedge ref_clk) disable iff (!resetn)
      (isStep(state_r) && !stepDone) |=> $stable(state_r)) else $error("step cut short");
   chk_step_exit: assert property (@(posedge ref_clk) disable iff (!resetn)
      (state_r == SQ_SUP_OUT && stepDone) |=> state_r == SQ_OUT_BIAS)
      else $error("step overran");
   chk_off_steps: assert property (@(posedge ref_clk) disable iff (!resetn)
      (state_r == SQ_OUT_SUP && stepDone) |=> state_r == SQ_OFF ##1 !controllerRun)
      else $error("off sequence end wrong");

   // assertions: pin order, a pin only moves while its neighbour is where it must be
   chk_bias_order: assert property (@(posedge ref_clk) disable iff (!resetn)
      $rose(panelPins.biasSupply) |-> panelPins.outputsOn) else $error("bias before outputs");
   chk_outputs_stop: assert property (@(posedge ref_clk) disable iff (!resetn)
      $fell(panelPins.outputsOn) |-> !panelPins.biasSupply)
      else $error("outputs stopped under bias");
   chk_supply_last: assert property (@(posedge ref_clk) disable iff (!resetn)
      ($fell(panelPins.logicSupply) && state_r == SQ_OFF) |-> !panelPins.outputsOn)
      else $error("supply dropped under outputs");
endmodule

// >>> rtl/lpps_pkg.sv
// package for the lcd panel power sequencer: register map, fields, states
// assumes a 32-bit apb slave with word-aligned registers
package lpps_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_PMODE  = 8'h00;
   localparam logic [7:0] ADDR_PSTEP  = 8'h04;
   localparam logic [7:0] ADDR_DCTRL  = 8'h08;
   localparam logic [7:0] ADDR_IRQCTL = 8'h0c;
   // panel_power_mode fields
   localparam int BIAS_EN_STEP_LSB  = 12;
   localparam int EN_BIAS_STEP_LSB  = 8;
   localparam int LOGIC_PIN_EN_BIT  = 6;
   localparam int BIAS_PIN_EN_BIT   = 5;
   localparam int DISP_PIN_EN_BIT   = 4;
   // panel_power_step_periods fields
   localparam int SUP_OUT_STEP_LSB  = 12;
   localparam int OUT_BIAS_STEP_LSB = 8;
   localparam int BIAS_OUT_STEP_LSB = 4;
   localparam int OUT_SUP_STEP_LSB  = 0;
   // display_control fields
   localparam int START_AUX_BIT     = 4;
   localparam int DISP_ON_BIT       = 0;
   // interrupt control fields
   localparam int IRQ_POINT_BIT     = 12;
   localparam int IRQ_EN_BIT        = 8;
   localparam int IRQ_FLAG_BIT      = 0;
   localparam logic [15:0] PMODE_RST     = 16'h0010;
   localparam logic [15:0] PMODE_WMASK   = 16'hff70; // bits 7, 3..0 are not writable
   localparam logic [15:0] PSTEP_RST     = 16'h0000;
   localparam logic [1:0]  PWR_STATE_OFF = 2'b00;
   localparam logic [1:0]  PWR_STATE_ON  = 2'b11;
   localparam int STEP_W = 4;
   // sequencer states, gray along on-path then off-path
   typedef enum logic [2:0] {
      SQ_OFF      = 3'b000,
      SQ_SUP_OUT  = 3'b001,
      SQ_OUT_BIAS = 3'b011,
      SQ_BIAS_EN  = 3'b010,
      SQ_ON       = 3'b110,
      SQ_EN_BIAS  = 3'b111,
      SQ_BIAS_OUT = 3'b101,
      SQ_OUT_SUP  = 3'b100
   } lpps_state_e;
   // pin group towards the panel
   typedef struct packed {
      logic logicSupply;
      logic biasSupply;
      logic dispEnable;
      logic outputsOn;
   } lpps_pins_s;
endpackage

// >>> testbench/lpps_panel_model.sv
// stand-in for the timing generator beside the panel: frame and retrace pulses
// assumes it shares ref_clk and resetn with the sequencer
`timescale 1ns/100ps
module lpps_panel_model
   import lpps_pkg::*;
(
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic resetn,
   // from the sequencer
   input  wire logic controllerRun,
   // timing events
   output logic      frameTick,
   output logic      memRetraceStart,
   output logic      dispRetraceStart
);
   logic [2:0] phase_r;
   // eight-cycle frames; the generator stands still while the controller is stopped
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) phase_r <= 3'h0;
      else if (!controllerRun) phase_r <= 3'h0;
      else phase_r <= phase_r + 3'h1;
   end
   // retrace points kept apart so a flag clear never meets a set; no memory
   // fetch is modelled, so bus load stays far below the limit
   assign memRetraceStart  = controllerRun && phase_r == 3'h1;
   assign dispRetraceStart = controllerRun && phase_r == 3'h5;
   assign frameTick        = controllerRun && phase_r == 3'h7;
endmodule

// >>> testbench/lpps_top_test.sv
// testbench for the panel power sequencer: apb tasks and sequence checks
// assumes the panel model supplies frame and retrace pulses
`timescale 1ns/100ps
module lpps_top_test
   import lpps_pkg::*;
;
   logic        ref_clk, resetn, psel, penable, pwrite, pready, pslverr, err;
   logic        frameTick, memRetraceStart, dispRetraceStart, controllerRun, panelCtrlIrq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   lpps_pins_s  panelPins;
   int          errors, samples_checked, ticks, t0, t1, t2, t3;
   lpps_top lpps_top_i (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .frameTick(frameTick), .memRetraceStart(memRetraceStart),
      .dispRetraceStart(dispRetraceStart), .panelPins(panelPins),
      .controllerRun(controllerRun), .panelCtrlIrq(panelCtrlIrq));
   lpps_panel_model lpps_panel_model_i (.ref_clk(ref_clk), .resetn(resetn),
      .controllerRun(controllerRun), .frameTick(frameTick),
      .memRetraceStart(memRetraceStart), .dispRetraceStart(dispRetraceStart));
   always #2.5 ref_clk = ~ref_clk;
   // frame count, used to measure step lengths between pin edges
   always @(posedge ref_clk) if (frameTick === 1'b1) ticks <= ticks + 1;
   task automatic finish_test();
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic timeout();
      errors++;
      finish_test();
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer; a leading edge keeps back-to-back calls from colliding
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) timeout();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   // software waits for the final power state before touching the display bit
   task automatic pollLps(input logic [1:0] v);
      int n;
      n = 0;
      do begin
         apb(1'b0, ADDR_PMODE, 32'h0);
         n++;
      end while (rd[1:0] !== v && n < 100);
      if (n >= 100) timeout();
   endtask
   task automatic waitPin(input int b, input logic v, output int t);
      int n;
      n = 0;
      while (panelPins[b] !== v && n < 500) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      if (n >= 500) timeout();
      t = ticks;
   endtask
   // k: 0 memory retrace, 1 display retrace, 2 interrupt output
   task automatic waitEv(input int k);
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while ((k == 0 ? memRetraceStart : k == 1 ? dispRetraceStart : panelCtrlIrq)
                 !== 1'b1 && n < 100);
      if (n >= 100) timeout();
   endtask
   initial begin
      {ref_clk, resetn, psel, penable, pwrite, paddr, pwdata, ticks} = '0;
      repeat (4) @(posedge ref_clk);
      resetn <= 1'b1;
      rdchk(ADDR_PMODE, 32'h0010);
      rdchk(ADDR_PSTEP, 32'h0);
      rdchk(ADDR_DCTRL, 32'h0);
      rdchk(ADDR_IRQCTL, 32'h0);
      apb(1'b1, ADDR_PMODE, 32'hffff);
      rdchk(ADDR_PMODE, 32'hff70);
      rdchk(8'h10, 32'h0);
      chk(err, 1'b1);
      // all pin enables off: supplies and display enable stay low
      apb(1'b1, ADDR_PMODE, 32'h0);
      apb(1'b1, ADDR_DCTRL, 32'h11);
      pollLps(2'b11);
      @(posedge ref_clk);
      #1;
      chk(panelPins, 4'h1);
      rdchk(ADDR_IRQCTL, 32'h0);
      apb(1'b1, ADDR_DCTRL, 32'h0);
      pollLps(2'b00);
      repeat (2) @(posedge ref_clk);
      chk(controllerRun, 1'b0);
      // full sequence with all pins enabled
      apb(1'b1, ADDR_IRQCTL, 32'h1100);
      apb(1'b1, ADDR_PMODE, 32'h2170);
      apb(1'b1, ADDR_PSTEP, 32'h1320);
      apb(1'b1, ADDR_DCTRL, 32'h11);
      waitPin(3, 1'b1, t0);
      waitPin(0, 1'b1, t1);
      waitPin(2, 1'b1, t2);
      waitPin(1, 1'b1, t3);
      chk(t1 - t0, 2);
      chk(t2 - t1, 4);
      chk(t3 - t2, 3);
      rdchk(ADDR_DCTRL, 32'h1);
      rdchk(ADDR_PMODE, 32'h2173);
      chk(controllerRun, 1'b1);
      apb(1'b1, ADDR_IRQCTL, 32'h1100);
      waitEv(2);
      rdchk(ADDR_IRQCTL, 32'h1101);
      waitEv(0);
      apb(1'b1, ADDR_IRQCTL, 32'h0100);
      waitEv(1);
      #1;
      chk(panelCtrlIrq, 1'b0);
      waitEv(0);
      #1;
      chk(panelCtrlIrq, 1'b1);
      apb(1'b1, ADDR_DCTRL, 32'h0);
      waitPin(1, 1'b0, t0);
      waitPin(2, 1'b0, t1);
      waitPin(0, 1'b0, t2);
      waitPin(3, 1'b0, t3);
      chk(t1 - t0, 2);
      chk(t2 - t1, 3);
      chk(t3 - t2, 1);
      rdchk(ADDR_PMODE, 32'h2170);
      chk(controllerRun, 1'b0);
      finish_test();
   end
endmodule
